// >>> rtl/burst_pkg.sv
// Constants for the locator burst scheduler: register map, field layouts,
// default field values and sequence positions.
// Assumes every user writes package::name; nothing is imported.
package burst_pkg;

  // Register map, byte addresses on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_INCR = 4'h8;

  // Control register bits
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_START_AIS2 = 1;
  localparam int CTRL_TEST_GO = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register bits
  localparam int ST_BURST_LSB = 0;
  localparam int ST_BUSY = 3;
  localparam int ST_TEST_DONE = 4;
  localparam int ST_FIX_LOST = 5;
  localparam int ST_WAIT_FIX = 6;

  // Report field values
  localparam logic [3:0] NAV_ACTIVE = 4'he;
  localparam logic [3:0] NAV_TEST = 4'hf;
  localparam logic [27:0] LON_NA = 28'h6791ac0;
  localparam logic [26:0] LAT_NA = 27'h3412140;
  localparam logic [11:0] COG_NA = 12'he10;
  localparam logic [9:0] SOG_NA = 10'h3ff;
  localparam logic [5:0] STAMP_NA = 6'h3f;
  localparam logic [1:0] SYNC_NORMAL = 2'h0;
  localparam logic [1:0] SYNC_HELD = 2'h3;

  // Burst sequence positions
  localparam logic [2:0] LAST_MSG = 3'h7;
  localparam logic [2:0] TEXT_POS_A = 3'h4;
  localparam logic [2:0] TEXT_POS_B = 3'h5;
  localparam logic [2:0] TEST_TEXT_FIRST = 3'h0;
  localparam logic [2:0] BURST_TEXT_A = 3'h0;
  localparam logic [2:0] BURST_TEXT_B = 3'h4;
  localparam logic [2:0] BURST_UTC = 3'h6;
  localparam logic [2:0] BURST_INCR = 3'h7;
  localparam logic [2:0] TIMEOUT_FIRST = 3'h7;
  localparam logic [2:0] TIMEOUT_TEST = 3'h0;
  localparam logic [13:0] SUB_ZERO = 14'h0000;
  localparam logic [1:0] UTC_PAD = 2'h0;

  // Random slot increment, inclusive range
  localparam logic [11:0] INCR_MIN = 12'h7e9;
  localparam logic [8:0] INCR_SPAN_MAX = 9'h1c2;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // Minute ticks a test waits for a fix before sending defaults
  localparam logic [2:0] TEST_WAIT_MINUTES = 3'h6;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT_FIX = 2'b01,
    S_SEND = 2'b11,
    S_FINISH = 2'b10
  } state_type;

endpackage

// >>> rtl/slot_increment_random.sv
// Random slot increment for the last burst of a cycle.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module slot_increment_random (
  input wire logic clk,
  input wire logic rst,
  output logic [11:0] incr
);

  logic [15:0] lfsr_q;
  logic [8:0] span_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lfsr_q <= burst_pkg::LFSR_SEED;
    end
    else
    begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // Rejection keeps the draw uniform
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      span_q <= 9'h000;
    end
    else if (lfsr_q[8:0] <= burst_pkg::INCR_SPAN_MAX)
    begin
      span_q <= lfsr_q[8:0]; // RL11
    end
  end

  assign incr = burst_pkg::INCR_MIN + {3'h0, span_q}; // RL11

endmodule

// >>> rtl/fix_hold.sv
// Position source: live fix, held last fix, or not-available defaults.
// Assumes GNSS inputs are synchronous and stable while fixValid is high.
`timescale 1ns/1ps
module fix_hold (
  input wire logic clk,
  input wire logic rst,
  input wire logic clearHistory,
  input wire logic fixValid,
  input wire logic [27:0] gnssLon,
  input wire logic [26:0] gnssLat,
  input wire logic [11:0] gnssCog,
  input wire logic [9:0] gnssSog,
  input wire logic [5:0] gnssSecond,
  output logic [27:0] repLon,
  output logic [26:0] repLat,
  output logic [11:0] repCog,
  output logic [9:0] repSog,
  output logic [5:0] repStamp,
  output logic [1:0] repSync,
  output logic fixLost
);

  logic seen_q;
  logic [27:0] lon_q;
  logic [26:0] lat_q;
  logic [11:0] cog_q;
  logic [9:0] sog_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seen_q <= 1'b0;
    end
    else if (fixValid)
    begin
      seen_q <= 1'b1;
    end
    else if (clearHistory)
    begin
      seen_q <= 1'b0;
    end
  end

  // Last known data, defaults until a fix arrives
  always_ff @(posedge clk)
  begin
    if (rst || (clearHistory && !fixValid))
    begin
      lon_q <= burst_pkg::LON_NA;
      lat_q <= burst_pkg::LAT_NA;
      cog_q <= burst_pkg::COG_NA;
      sog_q <= burst_pkg::SOG_NA;
    end
    else if (fixValid)
    begin
      lon_q <= gnssLon;
      lat_q <= gnssLat;
      cog_q <= gnssCog;
      sog_q <= gnssSog;
    end
  end

  assign fixLost = seen_q && !fixValid;
  assign repLon = fixValid ? gnssLon : lon_q; // RL15 RL16
  assign repLat = fixValid ? gnssLat : lat_q; // RL15 RL16
  assign repCog = fixValid ? gnssCog : cog_q; // RL15 RL16
  assign repSog = fixValid ? gnssSog : sog_q; // RL15 RL16
  assign repStamp = fixValid ? gnssSecond : burst_pkg::STAMP_NA; // RL15 RL16
  assign repSync = fixLost ? burst_pkg::SYNC_HELD : burst_pkg::SYNC_NORMAL; // RL17

endmodule

// >>> rtl/locator_burst_scheduler.sv
// Burst scheduler and report field generator for a personal locating beacon.
// Assumes a modulator that takes one message per msgValid/msgReady handshake,
// a one-cycle minuteTick at each UTC minute and synchronous GNSS inputs.
//
// What this block does
// RL1 - Active: eight-message burst every minute
// RL2 - Communication state pre-announces future slots
// RL3 - Active reports carry status 14
// RL4 - Active text each four minutes, both channels
// RL5 - Messages alternate between the two channels
// RL6 - Bursts 1,5: text at 5,6; time-out 7,3
// RL7 - Bursts 2,4,6: time-out 6,4,2, slot number
// RL8 - Burst 3: time-out 5, sub-message zero
// RL9 - Burst 7: time-out 1, UTC hour/minute
// RL10 - Burst 8: time-out 0, slot increment
// RL11 - Increment uniform random, 2025 to 2475
// RL12 - Restart at burst 1; may start AIS2
// RL13 - Test: eight messages, text first and last
// RL14 - Test middle reports: status 15, zeros
// RL15 - No fix: defaults, timestamp 63
// RL16 - Fix lost: hold last data, timestamp 63
// RL17 - Held data uses sync state 3
// RL18 - Test waits for valid fix
// RL19 - Test stops after its single burst
// RL20 - Three-bit burst index selects burst content
`timescale 1ns/1ps
module locator_burst_scheduler (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic minuteTick,
  input wire logic fixValid,
  input wire logic [27:0] gnssLon,
  input wire logic [26:0] gnssLat,
  input wire logic [11:0] course_over_ground,
  input wire logic [9:0] speed_over_ground,
  input wire logic [5:0] gnssSecond,
  input wire logic [4:0] utcHour,
  input wire logic [6:0] utcMinute,
  input wire logic [13:0] slotNumber,
  output logic msgValid,
  input wire logic msgReady,
  output logic msgIsText,
  output logic msgIsTest,
  output logic msgChannel,
  output logic [3:0] msgNavStatus,
  output logic [2:0] msgTimeout,
  output logic [13:0] msgSubMessage,
  output logic [1:0] msgSyncState,
  output logic [27:0] msgLon,
  output logic [26:0] msgLat,
  output logic [11:0] msgCog,
  output logic [9:0] msgSog,
  output logic [5:0] msgStamp
);

  burst_pkg::state_type state_q;
  logic activeEn_q;
  logic startAis2_q;
  logic testMode_q;
  logic testDone_q;
  logic [2:0] burstIdx_q;
  logic [2:0] msgIdx_q;
  logic channel_q;
  logic [2:0] waitMin_q;
  logic valid_q;
  logic [31:0] rdata_q;
  logic [11:0] incrLast_q;
  logic testGo;
  logic activeRise;
  logic [11:0] incrNow;
  logic [27:0] repLon;
  logic [26:0] repLat;
  logic [11:0] repCog;
  logic [9:0] repSog;
  logic [5:0] repStamp;
  logic [1:0] repSync;
  logic fixLost;
  logic isText;
  logic [13:0] subNow;
  logic lastAccept;
  logic activeRiseHist;

  assign testGo = regWrite && (regAddr == burst_pkg::OFF_CTRL)
    && regWdata[burst_pkg::CTRL_TEST_GO] && (state_q == burst_pkg::S_IDLE)
    && !activeEn_q;
  assign activeRise = regWrite && (regAddr == burst_pkg::OFF_CTRL)
    && regWdata[burst_pkg::CTRL_ACTIVE] && !activeEn_q;
  assign activeRiseHist = activeRise || testGo;
  assign lastAccept = valid_q && msgReady && (msgIdx_q == burst_pkg::LAST_MSG);

  slot_increment_random u_rand (
    .clk(clk),
    .rst(rst),
    .incr(incrNow)
  );

  fix_hold u_fix (
    .clk(clk),
    .rst(rst),
    .clearHistory(activeRiseHist),
    .fixValid(fixValid),
    .gnssLon(gnssLon),
    .gnssLat(gnssLat),
    .gnssCog(course_over_ground),
    .gnssSog(speed_over_ground),
    .gnssSecond(gnssSecond),
    .repLon(repLon),
    .repLat(repLat),
    .repCog(repCog),
    .repSog(repSog),
    .repStamp(repStamp),
    .repSync(repSync),
    .fixLost(fixLost)
  );

  // Control register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {startAis2_q, activeEn_q} <= burst_pkg::CTRL_RESET;
    end
    else if (regWrite && (regAddr == burst_pkg::OFF_CTRL))
    begin
      activeEn_q <= regWdata[burst_pkg::CTRL_ACTIVE];
      startAis2_q <= regWdata[burst_pkg::CTRL_START_AIS2];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (regRead)
    begin
      unique case (regAddr)
        burst_pkg::OFF_CTRL:
        begin
          rdata_q <= {30'h0000_0000, startAis2_q, activeEn_q};
        end
        burst_pkg::OFF_STATUS:
        begin
          rdata_q <= {25'h000_0000, state_q == burst_pkg::S_WAIT_FIX, fixLost,
            testDone_q, state_q != burst_pkg::S_IDLE, burstIdx_q};
        end
        burst_pkg::OFF_INCR:
        begin
          rdata_q <= {20'h0_0000, incrLast_q};
        end
        default:
        begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
    else
    begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign regRdata = rdata_q;

  // Sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= burst_pkg::S_IDLE;
    end
    else
    begin
      unique case (state_q)
        burst_pkg::S_IDLE:
        begin
          if (testGo)
          begin
            state_q <= burst_pkg::S_WAIT_FIX;
          end
          else if (activeEn_q && minuteTick)
          begin
            state_q <= burst_pkg::S_SEND; // RL1
          end
        end
        burst_pkg::S_WAIT_FIX:
        begin
          if (fixValid || (minuteTick && waitMin_q == burst_pkg::TEST_WAIT_MINUTES))
          begin
            state_q <= burst_pkg::S_SEND; // RL18
          end
        end
        burst_pkg::S_SEND:
        begin
          if (lastAccept)
          begin
            state_q <= burst_pkg::S_FINISH;
          end
        end
        burst_pkg::S_FINISH:
        begin
          state_q <= burst_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Test minute counter while waiting for a fix
  always_ff @(posedge clk)
  begin
    if (rst || state_q != burst_pkg::S_WAIT_FIX)
    begin
      waitMin_q <= 3'h0;
    end
    else if (minuteTick && waitMin_q != burst_pkg::TEST_WAIT_MINUTES)
    begin
      waitMin_q <= waitMin_q + 3'h1;
    end
  end

  // Test mode flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      testMode_q <= 1'b0;
      testDone_q <= 1'b0;
    end
    else if (testGo)
    begin
      testMode_q <= 1'b1;
      testDone_q <= 1'b0;
    end
    else if (state_q == burst_pkg::S_FINISH && testMode_q)
    begin
      testMode_q <= 1'b0; // RL19
      testDone_q <= 1'b1; // RL19
    end
  end

  // Burst index, advanced after each completed active burst
  always_ff @(posedge clk)
  begin
    if (rst || activeRise)
    begin
      burstIdx_q <= 3'h0;
    end
    else if (state_q == burst_pkg::S_FINISH && !testMode_q)
    begin
      burstIdx_q <= burstIdx_q + 3'h1; // RL20 RL12
    end
  end

  // Increment announced in the last burst, kept for readback
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      incrLast_q <= burst_pkg::INCR_MIN;
    end
    else if (state_q == burst_pkg::S_IDLE && activeEn_q && minuteTick
      && burstIdx_q == burst_pkg::BURST_INCR)
    begin
      incrLast_q <= incrNow; // RL11
    end
  end

  // Message position and channel
  always_ff @(posedge clk)
  begin
    if (rst || state_q != burst_pkg::S_SEND)
    begin
      msgIdx_q <= 3'h0;
      channel_q <= startAis2_q; // RL12
    end
    else if (valid_q && msgReady)
    begin
      msgIdx_q <= msgIdx_q + 3'h1;
      channel_q <= !channel_q; // RL5
    end
  end

  // Text slots and sub-message content for the current position
  always_comb
  begin
    if (testMode_q)
    begin
      isText = (msgIdx_q == burst_pkg::TEST_TEXT_FIRST)
        || (msgIdx_q == burst_pkg::LAST_MSG); // RL13
      subNow = burst_pkg::SUB_ZERO; // RL14
    end
    else
    begin
      isText = (burstIdx_q == burst_pkg::BURST_TEXT_A || burstIdx_q == burst_pkg::BURST_TEXT_B)
        && (msgIdx_q == burst_pkg::TEXT_POS_A || msgIdx_q == burst_pkg::TEXT_POS_B); // RL4 RL6
      if (burstIdx_q == burst_pkg::BURST_INCR)
      begin
        subNow = {2'h0, incrLast_q}; // RL10
      end
      else if (burstIdx_q == burst_pkg::BURST_UTC)
      begin
        subNow = {utcHour, utcMinute, burst_pkg::UTC_PAD}; // RL9
      end
      else if (burstIdx_q[0])
      begin
        subNow = slotNumber; // RL7
      end
      else
      begin
        subNow = burst_pkg::SUB_ZERO; // RL6 RL8
      end
    end
  end

  // Message valid and field registers
  always_ff @(posedge clk)
  begin
    if (rst || state_q != burst_pkg::S_SEND)
    begin
      valid_q <= 1'b0;
    end
    else if (valid_q && msgReady)
    begin
      valid_q <= 1'b0;
    end
    else if (!lastAccept)
    begin
      valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      msgIsText <= 1'b0;
      msgIsTest <= 1'b0;
      msgChannel <= 1'b0;
      msgNavStatus <= burst_pkg::NAV_ACTIVE;
      msgTimeout <= burst_pkg::TIMEOUT_TEST;
      msgSubMessage <= burst_pkg::SUB_ZERO;
      msgSyncState <= burst_pkg::SYNC_NORMAL;
      msgLon <= burst_pkg::LON_NA;
      msgLat <= burst_pkg::LAT_NA;
      msgCog <= burst_pkg::COG_NA;
      msgSog <= burst_pkg::SOG_NA;
      msgStamp <= burst_pkg::STAMP_NA;
    end
    else if (state_q == burst_pkg::S_SEND && !valid_q)
    begin
      msgIsText <= isText;
      msgIsTest <= testMode_q;
      msgChannel <= channel_q; // RL5
      msgNavStatus <= testMode_q ? burst_pkg::NAV_TEST : burst_pkg::NAV_ACTIVE; // RL3 RL14
      msgTimeout <= testMode_q ? burst_pkg::TIMEOUT_TEST
        : burst_pkg::TIMEOUT_FIRST - burstIdx_q; // RL2 RL6 RL7 RL8 RL9 RL10 RL14
      msgSubMessage <= subNow; // RL2
      msgSyncState <= repSync; // RL17
      msgLon <= repLon; // RL15 RL16
      msgLat <= repLat;
      msgCog <= repCog;
      msgSog <= repSog;
      msgStamp <= repStamp;
    end
  end

  assign msgValid = valid_q;

endmodule

// >>> verif/modulator_model.sv
// Modulator stand-in: accepts one message per valid/ready handshake.
// Assumes msgValid holds until accepted; slow adds a five-cycle stall.
`timescale 1ns/1ps
module modulator_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic msgValid,
  input wire logic slow,
  output logic msgReady
);
  logic [3:0] stall_q;

  // Ready is a one-cycle pulse once the stall has run out
  always_ff @(posedge clk)
  begin
    if (rst || !msgValid || msgReady)
    begin
      msgReady <= 1'b0;
      stall_q <= slow ? 4'h5 : 4'h0;
    end
    else if (stall_q == 4'h0)
    begin
      msgReady <= 1'b1;
    end
    else
    begin
      stall_q <= stall_q - 4'h1;
    end
  end
endmodule

// >>> verif/locator_burst_scheduler_props.sv
// Checker for the message stream of the burst scheduler.
// Assumes it is bound to the scheduler top and sees its ports only.
`timescale 1ns/1ps
module locator_burst_scheduler_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] slotNumber,
  input wire logic msgValid,
  input wire logic msgReady,
  input wire logic msgIsText,
  input wire logic msgIsTest,
  input wire logic msgChannel,
  input wire logic [3:0] msgNavStatus,
  input wire logic [2:0] msgTimeout,
  input wire logic [13:0] msgSubMessage,
  input wire logic [1:0] msgSyncState,
  input wire logic [5:0] msgStamp
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_accept;
    msgValid && msgReady;
  endsequence
  sequence s_accept_report;
    msgValid && msgReady && !msgIsText;
  endsequence
  sequence s_report;
    msgValid && !msgIsText && !msgIsTest;
  endsequence

  a_chan_alt: assert property (
    s_accept ##2 msgValid |-> msgChannel != $past(msgChannel, 2))
    else $error("channel did not alternate");
  a_hold_fields: assert property (
    msgValid && !msgReady |=> msgValid && $stable(msgChannel) && $stable(msgSubMessage))
    else $error("message dropped or changed before acceptance");
  a_timeout_const: assert property (
    s_accept_report ##2 (msgValid && !msgIsText)
    |-> msgTimeout == $past(msgTimeout, 2) && msgIsTest == $past(msgIsTest, 2))
    else $error("time-out changed inside a burst");
  a_nav_active: assert property (
    s_report |-> msgNavStatus == 4'he)
    else $error("active report status wrong");
  a_nav_test: assert property (
    msgValid && msgIsTest && !msgIsText
    |-> msgNavStatus == 4'hf && msgTimeout == 3'h0 && msgSubMessage == 14'h0)
    else $error("test report fields wrong");
  a_sub_zero: assert property (
    s_report ##0 (msgTimeout inside {3'h7, 3'h5, 3'h3}) |-> msgSubMessage == 14'h0)
    else $error("sub-message not zero");
  a_sub_slot: assert property (
    s_report ##0 $rose(msgValid) ##0 (msgTimeout inside {3'h6, 3'h4, 3'h2})
    |-> msgSubMessage == $past(slotNumber))
    else $error("sub-message not slot number");
  a_incr_range: assert property (
    s_report ##0 (msgTimeout == 3'h0) |-> msgSubMessage inside {[14'h7e9:14'h9ab]})
    else $error("slot increment out of range");
  a_stamp_held: assert property (
    msgValid && msgSyncState == 2'h3 |-> msgStamp == 6'h3f)
    else $error("held data without stamp 63");
endmodule

bind locator_burst_scheduler locator_burst_scheduler_props i_locator_burst_scheduler_props (
  .clk, .rst, .slotNumber, .msgValid, .msgReady, .msgIsText, .msgIsTest, .msgChannel,
  .msgNavStatus, .msgTimeout, .msgSubMessage, .msgSyncState, .msgStamp
);

// >>> verif/locator_burst_scheduler_tb.sv
// Bench: active cycle with fix loss, register reads, test mode.
// Assumes the modulator model and the bound checker are compiled too.
`timescale 1ns/1ps
module locator_burst_scheduler_tb;
  logic clk = 0, rst = 1, regWrite = 0, regRead = 0, minuteTick = 0, fixValid = 0, slow = 0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0, regRdata, rnd = 32'hf8dea04c, rd;
  logic [27:0] gnssLon = 28'h0, msgLon, heldLon, lon;
  logic [26:0] gnssLat = 27'h0, msgLat;
  logic [11:0] course_over_ground = 12'h0, msgCog;
  logic [9:0] speed_over_ground = 10'h0, msgSog;
  logic [5:0] gnssSecond = 6'h0, msgStamp, st;
  logic [4:0] utcHour = 5'h0;
  logic [6:0] utcMinute = 7'h0;
  logic [13:0] slotNumber = 14'h0, msgSubMessage, s;
  logic msgValid, msgReady, msgIsText, msgIsTest, msgChannel, sc, t;
  logic [3:0] msgNavStatus;
  logic [2:0] msgTimeout;
  logic [1:0] msgSyncState, sy;
  logic [108:0] q[$];
  logic [108:0] m;
  logic [48:0] heldPos, pos;
  int err_total = 0, checked = 0, b, n, k;

  always #25 clk = ~clk;

  locator_burst_scheduler i_locator_burst_scheduler (
    .clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .minuteTick, .fixValid,
    .gnssLon, .gnssLat, .course_over_ground, .speed_over_ground, .gnssSecond, .utcHour,
    .utcMinute, .slotNumber, .msgValid, .msgReady, .msgIsText, .msgIsTest, .msgChannel,
    .msgNavStatus, .msgTimeout, .msgSubMessage, .msgSyncState, .msgLon, .msgLat, .msgCog,
    .msgSog, .msgStamp
  );
  modulator_model i_modulator_model (.clk, .rst, .msgValid, .slow, .msgReady);

  always @(posedge clk)
    if (msgValid && msgReady)
      q.push_back({msgIsText, msgIsTest, msgChannel, msgNavStatus, msgTimeout, msgSubMessage,
        msgSyncState, msgStamp, msgLon, msgLat, msgCog, msgSog});

  function automatic logic [31:0] nextRnd(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rdReg(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    rd = regRdata;
  endtask

  task automatic tick;
    @(posedge clk);
    minuteTick <= 1'b1;
    @(posedge clk);
    minuteTick <= 1'b0;
  endtask

  task automatic waitMsgs;
    for (int i = 0; i < 4000 && q.size() < 8; i++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    chk("message count", q.size(), 8);
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    err_total++;
    print_verdict;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(4'hc, 32'hffffffff);
    rdReg(4'hc);
    chk("unmapped", rd, 0);
    rdReg(4'h4);
    chk("status reset", rd, 0);
    rnd = nextRnd(rnd);
    sc = rnd[0];
    wr(4'h0, {30'h0, sc, 1'b1});
    for (n = 0; n < 9; n++)
    begin
      b = n % 8;
      rnd = nextRnd(rnd);
      slotNumber <= rnd[13:0];
      utcHour <= rnd[18:14];
      utcMinute <= rnd[25:19];
      gnssLon <= rnd[27:0];
      gnssSecond <= {1'b0, rnd[4:0]};
      fixValid <= (n >= 1 && n <= 4);
      slow <= n[0];
      s = (b == 6) ? {rnd[18:14], rnd[25:19], 2'b00} : (b % 2 == 1) ? rnd[13:0] : 14'h0;
      if (n >= 1 && n <= 4)
        heldLon = rnd[27:0];
      lon = (n == 0) ? burst_pkg::LON_NA : heldLon;
      st = (n >= 1 && n <= 4) ? {1'b0, rnd[4:0]} : burst_pkg::STAMP_NA;
      sy = (n >= 5) ? 2'h3 : 2'h0;
      rnd = nextRnd(rnd);
      gnssLat <= rnd[26:0];
      course_over_ground <= rnd[11:0];
      speed_over_ground <= rnd[9:0];
      if (n >= 1 && n <= 4)
        heldPos = {rnd[26:0], rnd[11:0], rnd[9:0]};
      pos = (n == 0) ? {burst_pkg::LAT_NA, burst_pkg::COG_NA, burst_pkg::SOG_NA} : heldPos;
      tick;
      if (n == 2)
      begin
        repeat (10) @(posedge clk);
        tick;
      end
      waitMsgs;
      rdReg(4'h4);
      chk("status", rd[6:0], {1'b0, n >= 5, 2'b00, 3'((b + 1) % 8)});
      if (b == 7)
      begin
        rdReg(4'h8);
        s = rd[13:0];
        chk("incr range", s >= 14'h7e9 && s <= 14'h9ab, 1);
      end
      for (k = 0; k < 8; k++)
      begin
        m = q.pop_front();
        t = (b == 0 || b == 4) && (k == 4 || k == 5);
        chk("kind", m[108:106], {t, 1'b0, sc ^ k[0]});
        if (!t)
        begin
          chk("fields", m[105:49], {4'he, 3'(7 - b), s, sy, st, lon});
          chk("position", m[48:0], pos);
        end
      end
    end
    wr(4'h0, 32'h0);
    fixValid <= 1'b0;
    wr(4'h0, 32'h6);
    repeat (3) tick;
    rdReg(4'h4);
    chk("wait fix", rd[6], 1);
    chk("early send", q.size(), 0);
    rnd = nextRnd(rnd);
    gnssLon <= rnd[27:0];
    gnssSecond <= {1'b0, rnd[4:0]};
    fixValid <= 1'b1;
    waitMsgs;
    for (k = 0; k < 8; k++)
    begin
      m = q.pop_front();
      t = (k == 0 || k == 7);
      chk("test kind", m[108:106], {t, 1'b1, ~k[0]});
      if (!t)
      begin
        chk("test fields", m[105:49], {4'hf, 3'h0, 16'h0, 1'b0, rnd[4:0], rnd[27:0]});
        chk("test position", m[48:0], {gnssLat, course_over_ground, speed_over_ground});
      end
    end
    repeat (3) tick;
    rdReg(4'h4);
    chk("test done", rd[4], 1);
    chk("extra send", q.size(), 0);
    fixValid <= 1'b0;
    wr(4'h0, 32'h4);
    repeat (6) tick;
    chk("fix wait limit", q.size(), 0);
    tick;
    waitMsgs;
    lon = burst_pkg::LON_NA;
    st = burst_pkg::STAMP_NA;
    pos = {burst_pkg::LAT_NA, burst_pkg::COG_NA, burst_pkg::SOG_NA};
    for (k = 0; k < 8; k++)
    begin
      m = q.pop_front();
      t = (k == 0 || k == 7);
      chk("default kind", m[108:106], {t, 1'b1, k[0]});
      if (!t)
      begin
        chk("default fields", m[105:49], {4'hf, 3'h0, 16'h0, st, lon});
        chk("default position", m[48:0], pos);
      end
    end
    print_verdict;
  end
endmodule
